/* pkg/jump_load_pkg.sv */
// Purpose: Shared constants and types for the register jump and byte load unit.
// Assumes: 32-bit registers, one execution request at a time.
// Notes: Each rule below except the software rules RQ5, RQ8, RQ13 and RQ14 is tagged where the logic carries it out.
// Overview of operation
// (RQ1) Delay slot executes before jump transfers.
// (RQ2) Target captured at jump issue.
// (RQ3) Flag zero: full target, mode unchanged.
// (RQ4) Flag set: bit0 cleared, copied to mode.
// (RQ5) Software puts only long instruction in slot.
// (RQ6) Full-set target with bit1 set faults.
// (RQ7) No full set: mode zero target faults.
// (RQ8) Software keeps control transfers out of slots.
// (RQ9) Barrier jump clears hazards before target fetch.
// (RQ10) Barrier jump needs no privilege check.
// (RQ11) Delay slot hazards stay uncleared.
// (RQ12) Only barrier jumps clear instruction hazards; exception return clears them too here.
// (RQ13) Software issues barrier after state writes.
// (RQ14) Software uses register 31 for returns.
// (RQ15) Address is sign-extended offset plus base.
// (RQ16) Signed load sign-extends byte into destination.
// (RQ17) Unsigned load zero-extends byte into destination.
// (RQ18) Endian xor on address and lane select.
// (RQ19) Jumps raise no exception; loads limited set.
// (RQ20) Misaligned target error reported at target fetch.
package jump_load_pkg;

  // Operation codes presented on the request port.
  localparam logic [2:0] OP_NONE = 3'h0;
  localparam logic [2:0] OP_REGISTER_JUMP = 3'h1;
  localparam logic [2:0] OP_REGISTER_JUMP_BARRIER = 3'h2;
  localparam logic [2:0] OP_SIGNED_BYTE_LOAD = 3'h3;
  localparam logic [2:0] OP_UNSIGNED_BYTE_LOAD = 3'h4;
  localparam logic [2:0] OP_OTHER = 3'h5;
  localparam logic [2:0] OP_EXCEPTION_RETURN = 3'h6;
  localparam logic [2:0] OP_EXECUTION_BARRIER = 3'h7;

  // Exception codes reported beside the error strobe.
  localparam logic [1:0] EXC_ADDRESS_ERROR = 2'h0;
  localparam logic [1:0] EXC_REFILL = 2'h1;
  localparam logic [1:0] EXC_INVALID = 2'h2;
  localparam logic [1:0] EXC_WATCH = 2'h3;

  // Reset values.
  localparam logic [31:0] PC_RESET = 32'h0000_0000;
  localparam logic MODE_RESET = 1'b0;

  // Lane position constants.
  localparam int LANE_BITS = 2;
  localparam int BYTE_WIDTH = 8;

  // Sequencer states, one-hot.
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SLOT = 4'h2,
    ST_LOAD = 4'h4,
    ST_FETCH = 4'h8
  } seq_state_type;

endpackage : jump_load_pkg

/* src/byte_lane_select.sv */
// Purpose: Pick and extend one byte out of a fetched memory word.
// Assumes: Word arrives registered from memory; lane already computed.
// Notes: Result leaves through a register one cycle later.
`timescale 1ns/100ps
module byte_lane_select #(
  parameter int WIDTH = 32
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Word and selection.
  input wire logic [WIDTH-1:0] word,
  input wire logic [1:0] lane,
  input wire logic sign_ext,
  // Extended result.
  output logic [WIDTH-1:0] result
);
  import jump_load_pkg::*;

  // State of this module is the registered result only.
  typedef struct packed {
    logic [WIDTH-1:0] result;
  } lane_state_type;

  lane_state_type lane_r;
  lane_state_type lane_nxt;
  logic [7:0] picked;

  // Select bits 7+8*lane down to 8*lane and extend to full width.
  always_comb begin
    picked = word[BYTE_WIDTH*lane +: BYTE_WIDTH]; // [RQ18]
    lane_nxt.result = {{(WIDTH-8){sign_ext & picked[7]}}, picked}; // [RQ16] [RQ17]
  end

  // Register the result.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      lane_r <= '0;
    end else begin
      lane_r <= lane_nxt;
    end
  end

  assign result = lane_r.result;

endmodule : byte_lane_select

/* src/register_jump_and_byte_load.sv */
// Purpose: Execute register jumps (plain and barrier) and byte loads.
// Assumes: One request per idle cycle; memory answers the cycle after the load strobe.
// Notes: Target fetch is modelled as a one-cycle fetch strobe with error check.
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/100ps
module register_jump_and_byte_load #(
  parameter int WIDTH = 32,
  parameter bit FULL_ISA = 1'b1
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Instruction request from the decoder.
  input wire logic req_valid,
  input wire logic [2:0] req_op,
  input wire logic [WIDTH-1:0] source_register,
  input wire logic [WIDTH-1:0] base_value,
  input wire logic [15:0] offset,
  input wire logic [4:0] destination_register,
  input wire logic compressed_isa_present,
  input wire logic reversed_byte_order,
  input wire logic big_byte_order,
  // Delay slot completion from the pipeline.
  input wire logic slot_done,
  input wire logic slot_hazard,
  // Hazard creation from system-coprocessor writes.
  input wire logic hazard_create,
  // Translation and memory interface.
  input wire logic [WIDTH-1:0] phys_addr,
  input wire logic [WIDTH-1:0] mem_word,
  input wire logic mem_fault,
  input wire logic [1:0] mem_fault_code,
  // Program counter and mode.
  output logic [WIDTH-1:0] pc,
  output logic instruction_set_mode,
  output logic fetch_strobe,
  // Load access outputs.
  output logic load_strobe,
  output logic [WIDTH-1:0] load_vaddr,
  output logic [WIDTH-1:0] load_paddr,
  output logic wb_valid,
  output logic [4:0] wb_reg,
  output logic [WIDTH-1:0] wb_data,
  // Hazard and exception status.
  output logic hazard_clear_action,
  output logic exec_hazard_pending,
  output logic instr_hazard_pending,
  output logic exc_valid,
  output logic [1:0] exc_code,
  output logic [WIDTH-1:0] exc_addr,
  output logic busy
);
  import jump_load_pkg::*;

  // All state of the unit in one packed record.
  typedef struct packed {
    seq_state_type state;
    logic [WIDTH-1:0] target;
    logic barrier;
    logic [WIDTH-1:0] pc;
    logic mode;
    logic fetch;
    logic load;
    logic [WIDTH-1:0] vaddr;
    logic [WIDTH-1:0] paddr;
    logic [1:0] lane;
    logic sign_ext;
    logic [4:0] dest;
    logic wb_pend;
    logic wb_valid;
    logic [4:0] wb_reg;
    logic [WIDTH-1:0] wb_data;
    logic clear;
    logic exec_haz;
    logic instr_haz;
    logic slot_haz;
    logic exc;
    logic [1:0] code;
    logic [WIDTH-1:0] exc_addr;
    logic busy;
  } unit_state_type;

  unit_state_type s_r;
  unit_state_type s_nxt;
  logic [WIDTH-1:0] lane_result;

  // Effective address: sign-extended offset plus base.
  function automatic logic [WIDTH-1:0] eff_addr(input logic [WIDTH-1:0] base,
                                                input logic [15:0] off);
    eff_addr = base + {{(WIDTH-16){off[15]}}, off}; // [RQ15]
  endfunction : eff_addr

  // Target fetch alignment check for the given mode bit and address.
  function automatic logic target_misaligned(input logic [WIDTH-1:0] tgt, input logic md);
    if (FULL_ISA) begin
      target_misaligned = !md && tgt[1]; // [RQ6]
    end else begin
      target_misaligned = !md; // [RQ7]
    end
  endfunction : target_misaligned

  // Lane extraction and extension, registered.
  byte_lane_select #(
    .WIDTH(WIDTH)
  ) u_lane (
    .clock(clock),
    .reset(reset),
    .word(mem_word),
    .lane(s_r.lane),
    .sign_ext(s_r.sign_ext),
    .result(lane_result)
  );

  // Next-state logic for the sequencer and all outputs.
  always_comb begin
    s_nxt = s_r;
    s_nxt.fetch = 1'b0;
    s_nxt.load = 1'b0;
    s_nxt.wb_valid = 1'b0;
    s_nxt.clear = 1'b0;
    s_nxt.exc = 1'b0;
    case (s_r.state)
      ST_IDLE: begin
        // Accept a new request only when idle.
        if (req_valid) begin
          if (req_op == OP_REGISTER_JUMP || req_op == OP_REGISTER_JUMP_BARRIER) begin
            // Barrier form has no privilege check at all.
            s_nxt.target = source_register; // [RQ2] [RQ10]
            s_nxt.barrier = (req_op == OP_REGISTER_JUMP_BARRIER);
            s_nxt.slot_haz = 1'b0;
            s_nxt.state = ST_SLOT; // [RQ1]
          end else if (req_op == OP_SIGNED_BYTE_LOAD || req_op == OP_UNSIGNED_BYTE_LOAD) begin
            s_nxt.vaddr = eff_addr(base_value, offset); // [RQ15]
            s_nxt.sign_ext = (req_op == OP_SIGNED_BYTE_LOAD);
            s_nxt.dest = destination_register;
            s_nxt.load = 1'b1;
            s_nxt.state = ST_LOAD;
          end else if (req_op == OP_EXECUTION_BARRIER) begin
            // Execution hazards alone are cleared here.
            s_nxt.exec_haz = 1'b0; // [RQ12]
          end else if (req_op == OP_EXCEPTION_RETURN) begin
            s_nxt.exec_haz = 1'b0; // [RQ12]
            s_nxt.instr_haz = 1'b0;
            s_nxt.clear = 1'b1;
          end
        end
      end
      ST_SLOT: begin
        // Wait for the delay slot to finish before redirecting.
        if (slot_done) begin
          if (!compressed_isa_present) begin
            s_nxt.pc = s_r.target; // [RQ3]
          end else begin
            s_nxt.pc = {s_r.target[WIDTH-1:1], 1'b0}; // [RQ4]
            s_nxt.mode = s_r.target[0]; // [RQ4]
          end
          if (s_r.barrier) begin
            // Clear earlier hazards; those from the slot survive.
            s_nxt.clear = 1'b1; // [RQ9]
            s_nxt.exec_haz = s_r.slot_haz | slot_hazard | hazard_create; // [RQ11]
            s_nxt.instr_haz = s_r.slot_haz | slot_hazard | hazard_create; // [RQ11]
          end else if (s_r.slot_haz || slot_hazard || hazard_create) begin
            // A plain jump clears nothing, so slot hazards become pending.
            s_nxt.exec_haz = 1'b1;
            s_nxt.instr_haz = 1'b1;
          end
          s_nxt.state = ST_FETCH;
        end
      end
      ST_FETCH: begin
        // Target fetch: alignment error is raised here, never by the jump.
        s_nxt.fetch = 1'b1; // [RQ19]
        if (target_misaligned(s_r.pc, s_r.mode)) begin
          s_nxt.exc = 1'b1; // [RQ20]
          s_nxt.code = EXC_ADDRESS_ERROR;
          s_nxt.exc_addr = s_r.pc; // [RQ20]
        end
        s_nxt.state = ST_IDLE;
      end
      ST_LOAD: begin
        if (s_r.load) begin
          // Strobe cycle: fix the lane now so the lane module sees it
          // together with the memory word at the next edge.
          s_nxt.lane = s_r.vaddr[1:0] ^ {LANE_BITS{big_byte_order}}; // [RQ18]
        end else begin
          // Memory word and translated address stand in this cycle.
          s_nxt.paddr = {phys_addr[WIDTH-1:2],
                         phys_addr[1:0] ^ {LANE_BITS{reversed_byte_order}}}; // [RQ18]
          if (mem_fault) begin
            s_nxt.exc = 1'b1; // [RQ19]
            s_nxt.code = mem_fault_code;
            s_nxt.exc_addr = s_r.vaddr;
          end else begin
            s_nxt.wb_pend = 1'b1;
          end
          s_nxt.state = ST_IDLE;
        end
      end
      default: begin
        s_nxt.state = ST_IDLE;
      end
    endcase
    // Hazards from coprocessor writes accumulate; a set in the same cycle
    // as a clear wins, so no freshly created hazard is ever lost.
    if (hazard_create) begin
      if (s_r.state == ST_SLOT) begin
        s_nxt.slot_haz = 1'b1; // [RQ11]
      end else begin
        s_nxt.exec_haz = 1'b1;
        s_nxt.instr_haz = 1'b1;
      end
    end
    // Writeback once the lane module has registered the byte.
    if (s_r.wb_pend && s_r.state == ST_IDLE) begin
      s_nxt.wb_pend = 1'b0;
      s_nxt.wb_valid = 1'b1; // [RQ16] [RQ17]
      s_nxt.wb_reg = s_r.dest;
      s_nxt.wb_data = lane_result; // [RQ16] [RQ17]
    end
    // Busy is registered so the output comes straight from a flip-flop.
    s_nxt.busy = (s_nxt.state != ST_IDLE);
  end

  // Register the whole state record.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s_r <= '0;
      s_r.state <= ST_IDLE;
      s_r.pc <= PC_RESET;
      s_r.mode <= MODE_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from flip-flops.
  assign pc = s_r.pc;
  assign instruction_set_mode = s_r.mode;
  assign fetch_strobe = s_r.fetch;
  assign load_strobe = s_r.load;
  assign load_vaddr = s_r.vaddr;
  assign load_paddr = s_r.paddr;
  assign wb_valid = s_r.wb_valid;
  assign wb_reg = s_r.wb_reg;
  assign wb_data = s_r.wb_data;
  assign hazard_clear_action = s_r.clear;
  assign exec_hazard_pending = s_r.exec_haz;
  assign instr_hazard_pending = s_r.instr_haz;
  assign exc_valid = s_r.exc;
  assign exc_code = s_r.code;
  assign exc_addr = s_r.exc_addr;
  assign busy = s_r.busy;

endmodule : register_jump_and_byte_load

/* test/jump_load_monitor.sv */
// Purpose: Concurrent checks on the jump and byte load unit ports.
// Assumes: One clock domain; reset is asynchronous and active high.
// Notes: Helper registers keep the last accepted request.
`timescale 1ns/100ps
module jump_load_monitor
  import jump_load_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter bit FULL_ISA = 1'b1
) (
  // Clock, reset and request side.
  input wire logic clock,
  input wire logic reset,
  input wire logic req_valid,
  input wire logic [2:0] req_op,
  input wire logic [WIDTH-1:0] source_register,
  input wire logic [WIDTH-1:0] base_value,
  input wire logic [15:0] offset,
  input wire logic compressed_isa_present,
  input wire logic slot_done,
  input wire logic busy,
  // Observed results.
  input wire logic [WIDTH-1:0] pc,
  input wire logic instruction_set_mode,
  input wire logic fetch_strobe,
  input wire logic load_strobe,
  input wire logic [WIDTH-1:0] load_vaddr,
  input wire logic wb_valid,
  input wire logic [WIDTH-1:0] wb_data,
  input wire logic hazard_clear_action,
  input wire logic exc_valid,
  input wire logic [1:0] exc_code,
  input wire logic [WIDTH-1:0] exc_addr
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // Copies of the accepted request, so checks see the target as issued.
  logic jp_r, bar_r, flag_r, sgn_r;
  logic [WIDTH-1:0] tgt_r, ea_r;
  logic done_w;
  assign done_w = slot_done && jp_r;
  // An accepted exception return also clears hazards.
  logic exception_return_w;
  assign exception_return_w = req_valid && !busy && req_op == OP_EXCEPTION_RETURN;
  // Capture on acceptance; the pending jump ends with the slot.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      jp_r <= 1'b0;
      bar_r <= 1'b0;
      flag_r <= 1'b0;
      sgn_r <= 1'b0;
      tgt_r <= '0;
      ea_r <= '0;
    end else if (req_valid && !busy) begin
      jp_r <= req_op == OP_REGISTER_JUMP || req_op == OP_REGISTER_JUMP_BARRIER;
      bar_r <= req_op == OP_REGISTER_JUMP_BARRIER;
      flag_r <= compressed_isa_present;
      sgn_r <= req_op == OP_SIGNED_BYTE_LOAD;
      tgt_r <= source_register;
      ea_r <= base_value + {{(WIDTH-16){offset[15]}}, offset};
    end else if (done_w) begin
      jp_r <= 1'b0;
    end
  end
  // The delay slot ends, then the target is fetched two cycles later.
  sequence jump_end;
    slot_done && jp_r;
  endsequence
  sequence fetch_step;
    !fetch_strobe ##1 fetch_strobe;
  endsequence
  pc_hold_a: assert property (!done_w |=> $stable(pc)) else $error("pc moved early");
  pc_full_a: assert property (jump_end ##0 !flag_r |=> pc == tgt_r
    && $stable(instruction_set_mode)) else $error("full target wrong");
  pc_mode_a: assert property (jump_end ##0 flag_r |=> pc == {tgt_r[WIDTH-1:1], 1'b0}
    && instruction_set_mode == tgt_r[0]) else $error("mode split wrong");
  clear_kind_a: assert property (jump_end |=> hazard_clear_action == bar_r)
    else $error("clear action wrong");
  clear_only_a: assert property (hazard_clear_action |-> ($past(done_w) && bar_r)
    || $past(exception_return_w)) else $error("stray clear action");
  fetch_after_a: assert property (jump_end |=> fetch_step) else $error("no fetch");
  fetch_fault_a: assert property (fetch_strobe |-> exc_valid == (FULL_ISA ?
    (!instruction_set_mode && pc[1]) : !instruction_set_mode))
    else $error("fetch fault wrong");
  fault_addr_a: assert property (fetch_strobe && exc_valid |-> exc_code == EXC_ADDRESS_ERROR
    && exc_addr == pc) else $error("fault report wrong");
  load_addr_a: assert property (load_strobe |-> load_vaddr == ea_r)
    else $error("load address wrong");
  load_ext_a: assert property (wb_valid |-> wb_data[WIDTH-1:8] ==
    (sgn_r ? {(WIDTH-8){wb_data[7]}} : '0)) else $error("extension wrong");
endmodule : jump_load_monitor
bind register_jump_and_byte_load jump_load_monitor #(.WIDTH(WIDTH), .FULL_ISA(FULL_ISA)) mon (
  .clock, .reset, .req_valid, .req_op, .source_register, .base_value, .offset,
  .compressed_isa_present, .slot_done, .busy, .pc, .instruction_set_mode, .fetch_strobe,
  .load_strobe, .load_vaddr, .wb_valid, .wb_data, .hazard_clear_action, .exc_valid,
  .exc_code, .exc_addr);

/* test/mem_model.sv */
// Purpose: Translation and data memory on the far side of the load port.
// Assumes: Answers are presented in the cycle after the load strobe.
// Notes: Outside that cycle every line shows a changing pattern.
`timescale 1ns/100ps
module mem_model (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Load request and test controls.
  input wire logic load_strobe,
  input wire logic [31:0] load_vaddr,
  input wire logic [31:0] word,
  input wire logic fault_en,
  input wire logic [1:0] fault_code,
  // Answer to the unit.
  output logic [31:0] phys_addr,
  output logic [31:0] mem_word,
  output logic mem_fault,
  output logic [1:0] mem_fault_code
);
  // Answer once per strobe; otherwise invert so stale values never look valid.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      phys_addr <= 32'h0;
      mem_word <= 32'h0;
      mem_fault <= 1'b0;
      mem_fault_code <= 2'h0;
    end else if (load_strobe) begin
      phys_addr <= load_vaddr ^ 32'h4000_0000;
      mem_word <= word;
      mem_fault <= fault_en;
      mem_fault_code <= fault_code;
    end else begin
      phys_addr <= ~phys_addr;
      mem_word <= ~mem_word;
      mem_fault <= ~mem_fault;
      mem_fault_code <= ~mem_fault_code;
    end
  end
endmodule : mem_model

/* test/tb.sv */
// Purpose: Directed test of register jumps, hazard clearing and byte loads.
// Assumes: The far side is the memory model; software never puts jumps in slots.
// Notes: jmp and ld each issue one request and wait for its completion; op_only issues none for OP_NONE.
`timescale 1ns/100ps
module tb;
  import jump_load_pkg::*;
  logic clock = 1'b0, reset = 1'b1, req_valid = 1'b0, slot_done = 1'b0, slot_hazard = 1'b0;
  logic hazard_create = 1'b0, compressed_isa_present = 1'b0, fault_en = 1'b0;
  logic reversed_byte_order = 1'b0, big_byte_order = 1'b0;
  logic [2:0] req_op = OP_NONE;
  logic [31:0] source_register = 32'h0, base_value = 32'h0, word = 32'h8E71_F20C;
  logic [15:0] offset = 16'h0;
  logic [4:0] destination_register = 5'h0, wb_reg;
  logic [1:0] fault_code = 2'h0, exc_code, mem_fault_code;
  logic [31:0] pc, load_vaddr, load_paddr, wb_data, exc_addr, phys_addr, mem_word;
  logic instruction_set_mode, fetch_strobe, load_strobe, wb_valid, hazard_clear_action;
  logic exec_hazard_pending, instr_hazard_pending, exc_valid, busy, mem_fault;
  int errors = 0, checked = 0, cycles = 0;
  register_jump_and_byte_load dut (.clock, .reset, .req_valid, .req_op, .source_register,
    .base_value, .offset, .destination_register, .compressed_isa_present,
    .reversed_byte_order, .big_byte_order, .slot_done, .slot_hazard, .hazard_create,
    .phys_addr, .mem_word, .mem_fault, .mem_fault_code, .pc, .instruction_set_mode,
    .fetch_strobe, .load_strobe, .load_vaddr, .load_paddr, .wb_valid, .wb_reg, .wb_data,
    .hazard_clear_action, .exec_hazard_pending, .instr_hazard_pending, .exc_valid,
    .exc_code, .exc_addr, .busy);
  mem_model mem (.clock, .reset, .load_strobe, .load_vaddr, .word, .fault_en, .fault_code,
    .phys_addr, .mem_word, .mem_fault, .mem_fault_code);
  initial forever #20 clock = ~clock;
  // A hung run is cut off and counted as a mismatch.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      final_report();
    end
  end
  task automatic final_report();
    if (errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Waits, bounded, until the unit is idle again.
  task automatic idle();
    for (int n = 0; n < 20 && busy !== 1'b0; n++) begin
      @(posedge clock);
      #1;
    end
    chk(busy, 1'b0);
  endtask : idle
  task automatic op_only(input logic [2:0] op, input logic hz);
    @(posedge clock);
    req_valid <= op != OP_NONE;
    req_op <= op;
    hazard_create <= hz;
    @(posedge clock);
    req_valid <= 1'b0;
    hazard_create <= 1'b0;
    #1;
    idle();
  endtask : op_only
  // The slot overwrites the source and may raise a slot hazard; it never holds a control transfer.
  task automatic jmp(input logic [2:0] op, input logic [31:0] src, input logic f, sh,
                     input logic [31:0] epc, input logic em, ee);
    @(posedge clock);
    req_valid <= 1'b1;
    req_op <= op;
    source_register <= src;
    compressed_isa_present <= f;
    @(posedge clock);
    req_valid <= 1'b0;
    source_register <= ~src;
    @(posedge clock);
    slot_done <= 1'b1;
    slot_hazard <= sh;
    @(posedge clock);
    slot_done <= 1'b0;
    slot_hazard <= 1'b0;
    @(posedge clock);
    #1;
    chk(fetch_strobe, 1'b1);
    chk(pc, epc);
    chk(instruction_set_mode, em);
    chk(exc_valid, ee);
    idle();
  endtask : jmp
  task automatic ld(input int i, input logic flt, input logic [1:0] code);
    logic [31:0] va;
    logic [1:0] ln;
    logic [7:0] b;
    va = 32'h0000_0FF0 + i;
    ln = va[1:0] ^ {2{i[3]}};
    b = word[8*ln +: 8];
    @(posedge clock);
    req_valid <= 1'b1;
    req_op <= i[2] ? OP_SIGNED_BYTE_LOAD : OP_UNSIGNED_BYTE_LOAD;
    base_value <= 32'h0000_1000;
    offset <= 16'hFFF0 + 16'(i);
    big_byte_order <= i[3];
    reversed_byte_order <= i[2] ^ i[3];
    destination_register <= 5'(i + 1);
    fault_en <= flt;
    fault_code <= code;
    @(posedge clock);
    req_valid <= 1'b0;
    for (int n = 0; n < 12 && (flt ? exc_valid : wb_valid) !== 1'b1; n++) begin
      @(posedge clock);
      #1;
    end
    if (flt) chk(exc_code, code);
    else begin
      chk(wb_data, i[2] ? {{24{b[7]}}, b} : {24'h0, b});
      chk(wb_reg, 32'(i + 1));
      chk(load_paddr, va ^ 32'h4000_0003 ^ {30'h0, {2{i[2] ^ i[3]}}} ^ 32'h3);
    end
    idle();
  endtask : ld
  initial begin
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    for (int i = 0; i < 16; i++) ld(i, 1'b0, EXC_REFILL);
    for (int c = 0; c < 4; c++) ld(5, 1'b1, 2'(c));
    op_only(OP_NONE, 1'b1);
    jmp(OP_REGISTER_JUMP, 32'h2001, 1'b1, 1'b0, 32'h2000, 1'b1, 1'b0);
    chk(instr_hazard_pending, 1'b1);
    jmp(OP_REGISTER_JUMP, 32'h5006, 1'b0, 1'b0, 32'h5006, 1'b1, 1'b0);
    jmp(OP_REGISTER_JUMP_BARRIER, 32'h3002, 1'b1, 1'b0, 32'h3002, 1'b0, 1'b1);
    chk({exec_hazard_pending, instr_hazard_pending}, 2'h0);
    op_only(OP_NONE, 1'b1);
    op_only(OP_EXECUTION_BARRIER, 1'b0);
    chk({exec_hazard_pending, instr_hazard_pending}, 2'h1);
    jmp(OP_REGISTER_JUMP_BARRIER, 32'h1234, 1'b0, 1'b1, 32'h1234, 1'b0, 1'b0);
    chk(instr_hazard_pending, 1'b1);
    op_only(OP_NONE, 1'b1);
    op_only(OP_EXCEPTION_RETURN, 1'b0);
    chk({exec_hazard_pending, instr_hazard_pending}, 2'h0);
    final_report();
  end
endmodule : tb
